// [logic/timer0_counter_prescaler.sv]
`timescale 1ns/1ps
`include "timer0_cfg.svh"
module timer0_counter_prescaler (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count input
  input logic ext_count_pin,
  // Processor sleep level
  input logic sleep,
  // Watchdog side of the shared prescaler
  input logic watchdog_tick,
  output logic watchdog_scaled_tick,
  // Interrupt
  output logic irq
);
  import timer0_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Low-bit mask of width w, for w of 0..8
  function automatic logic [7:0] low_mask(input logic [3:0] w);
    logic [8:0] m;
    m = 9'h000;
    m = (9'h001 << w) - 9'h001;
    return m[7:0];
  endfunction : low_mask

  // True when the address names a mapped register
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : addr_hit

  // Option byte into its fields; shared by reset and by software writes
  function automatic timer_state_t take_option(input timer_state_t st, input logic [7:0] v);
    timer_state_t t;
    t = st;
    t.src = v[`BIT_CLOCK_SOURCE_SELECT] ? src_pin : src_instr;
    t.edge_pol = v[`BIT_COUNT_EDGE_POLARITY];
    t.presc_assign = v[`BIT_PRESCALER_ASSIGN];
    t.ratio = v[`BIT_RATIO_HI:`BIT_RATIO_LO];
    return t;
  endfunction : take_option

  // Option byte as software reads it; bits 7:6 have no storage and read one
  function automatic logic [7:0] option_image(input timer_state_t st);
    logic [7:0] v;
    v = 8'hc0;
    v[`BIT_CLOCK_SOURCE_SELECT] = (st.src == src_pin);
    v[`BIT_COUNT_EDGE_POLARITY] = st.edge_pol;
    v[`BIT_PRESCALER_ASSIGN] = st.presc_assign;
    v[`BIT_RATIO_HI:`BIT_RATIO_LO] = st.ratio;
    return v;
  endfunction : option_image

  // Interrupt control byte: enable and sticky flag, all else reads zero
  function automatic logic [7:0] irq_image(input timer_state_t st);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_OVERFLOW_IRQ_ENABLE] = st.ovf_en;
    v[`BIT_OVERFLOW_FLAG] = st.ovf_flag;
    return v;
  endfunction : irq_image

  // Mask byte: one gate bit at the flag's position
  function automatic logic [7:0] mask_image(input timer_state_t st);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_OVERFLOW_FLAG] = st.ovf_mask;
    return v;
  endfunction : mask_image

  // Reset state built from the reset constants, so one table sets both
  function automatic timer_state_t reset_image();
    timer_state_t t;
    logic [7:0] ctl;
    logic [7:0] msk;
    t = '0;
    ctl = `RST_IRQ_CONTROL;
    msk = `RST_IRQ_MASK;
    t.count = `RST_COUNT_VALUE;
    t = take_option(t, `RST_OPTION);
    t.ovf_en = ctl[`BIT_OVERFLOW_IRQ_ENABLE];
    t.ovf_flag = ctl[`BIT_OVERFLOW_FLAG];
    t.ovf_mask = msk[`BIT_OVERFLOW_FLAG];
    return t;
  endfunction : reset_image

  // ----------------------------------------
  // State and wires
  // ----------------------------------------
  timer_state_t s_q;
  timer_state_t s_d;

  logic setup_phase;
  logic wr_access;
  logic wr_count;
  logic wr_option;
  logic wr_irq_ctl;
  logic wr_irq_mask;
  logic mapped;
  logic pin_edge;
  logic src_tick;
  logic presc_in;
  logic presc_out;
  logic presc_clear;
  logic [7:0] presc_mask;
  logic count_tick;
  logic do_inc;
  logic wrap;
  logic [31:0] read_mux;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // Zero wait states: access always completes in one cycle
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign mapped = addr_hit(paddr, `OFS_COUNT_VALUE) || addr_hit(paddr, `OFS_OPTION)
    || addr_hit(paddr, `OFS_IRQ_CONTROL) || addr_hit(paddr, `OFS_IRQ_MASK);
  assign wr_count = wr_access && addr_hit(paddr, `OFS_COUNT_VALUE);
  assign wr_option = wr_access && addr_hit(paddr, `OFS_OPTION);
  assign wr_irq_ctl = wr_access && addr_hit(paddr, `OFS_IRQ_CONTROL);
  assign wr_irq_mask = wr_access && addr_hit(paddr, `OFS_IRQ_MASK);

  // Read data, upper bits zero
  // Latched in the setup cycle, so a tick in the access cycle
  // cannot tear the value that software sees
  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (addr_hit(paddr, `OFS_COUNT_VALUE))
    begin
      read_mux[7:0] = s_q.count;
    end
    else if (addr_hit(paddr, `OFS_OPTION))
    begin
      read_mux[7:0] = option_image(s_q);
    end
    else if (addr_hit(paddr, `OFS_IRQ_CONTROL))
    begin
      read_mux[7:0] = irq_image(s_q);
    end
    else if (addr_hit(paddr, `OFS_IRQ_MASK))
    begin
      read_mux[7:0] = mask_image(s_q);
    end
  end

  // ----------------------------------------
  // Count source
  // ----------------------------------------

  // Edge seen on synchronised samples only; the raw pin may be metastable
  // Cost: three cycles from a pin change to the count update
  assign pin_edge = s_q.edge_pol ? (s_q.pin_s3 && !s_q.pin_s2)
                                 : (!s_q.pin_s3 && s_q.pin_s2);

  // Timer mode ticks every instruction cycle, counter mode on pin edges
  assign src_tick = (s_q.src == src_pin) ? pin_edge : 1'b1;

  // ----------------------------------------
  // Shared prescaler routing
  // ----------------------------------------

  // Assignment bit steers the one prescaler between counter and watchdog
  assign presc_in = s_q.presc_assign ? watchdog_tick : (src_tick && !sleep);
  assign count_tick = s_q.presc_assign ? src_tick : presc_out;
  assign watchdog_scaled_tick = s_q.presc_assign ? presc_out : watchdog_tick;

  // Counter side divides by 2^(n+1), watchdog side by 2^n
  assign presc_mask = s_q.presc_assign ? low_mask({1'b0, s_q.ratio})
                                       : low_mask({1'b0, s_q.ratio} + 4'h1);

  // A counter write restarts the prescaler so the new value gets a full period
  // Limitation: while the watchdog owns it, a write leaves its phase alone,
  // so the first scaled watchdog tick may come early
  assign presc_clear = wr_count && !s_q.presc_assign;

  prescaler_unit u_prescaler (
    .clock(clock),
    .rst_n(rst_n),
    .clear(presc_clear),
    .mask(presc_mask),
    .tick_in(presc_in),
    .tick_out(presc_out)
  );

  // ----------------------------------------
  // Increment and overflow
  // ----------------------------------------

  // Frozen in sleep and during the post-write hold-off
  // Ticks in the hold-off are dropped, not deferred; software
  // compensates by writing an adjusted value
  assign do_inc = count_tick && !sleep && (s_q.inhibit == 2'h0);
  // Pre-increment value, so flag and 00h appear on the same edge
  assign wrap = do_inc && (s_q.count == 8'hff);

  // Level request, gated by enable and mask
  // Either gate alone masks it; the flag itself stays sticky
  assign irq = s_q.ovf_flag && s_q.ovf_en && s_q.ovf_mask;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;

    // Two-stage synchroniser, then a history stage for edge detection
    s_d.pin_s1 = ext_count_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;

    // Counter, with write taking priority over increment
    // A new write restarts the hold-off rather than letting it run down
    if (wr_count)
    begin
      s_d.count = pwdata[7:0];
      s_d.inhibit = `WRITE_INHIBIT_CYCLES;
    end
    else
    begin
      if (s_q.inhibit != 2'h0)
      begin
        s_d.inhibit = s_q.inhibit - 2'h1;
      end
      if (do_inc)
      begin
        s_d.count = s_q.count + 8'h01;
      end
    end

    // Option register
    if (wr_option)
    begin
      s_d = take_option(s_d, pwdata[7:0]);
    end

    // Interrupt control: enable is plain, flag is write-one-to-clear
    if (wr_irq_ctl)
    begin
      s_d.ovf_en = pwdata[`BIT_OVERFLOW_IRQ_ENABLE];
      if (pwdata[`BIT_OVERFLOW_FLAG])
      begin
        s_d.ovf_flag = 1'b0;
      end
    end
    if (wr_irq_mask)
    begin
      s_d.ovf_mask = pwdata[`BIT_OVERFLOW_FLAG];
    end

    // Set wins over a clear in the same cycle, so no wrap is lost
    if (wrap)
    begin
      s_d.ovf_flag = 1'b1;
    end

    // Read data and error captured in setup, presented in access
    // Unmapped addresses read zero and raise the error response
    if (setup_phase)
    begin
      s_d.rdata = read_mux;
      s_d.slverr = !mapped;
    end
  end

  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset loads one constant image of the whole state
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= reset_image();
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : timer0_counter_prescaler

// [include/timer0_cfg.svh]
// Contract
// - Counter is 8-bit, read/write, wraps
// - Select clear: count every instruction cycle
// - Counter write blocks increments for the next two cycles
// - Select set: count external pin edges
// - Polarity clear rising, set falling edge
// - Prescaler shared: assign clear means counter
// - Prescaler 8-bit, ratio chosen by software
// - Prescaler count hidden from software
// - Counter ratios powers of two, 2..256
// - Wrap FFh to 00h sets overflow flag
// - Request raised only while enable set
// - Counter stops during sleep
`ifndef TIMER0_CFG_SVH
`define TIMER0_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_COUNT_VALUE 8'h00
`define OFS_OPTION 8'h04
`define OFS_IRQ_CONTROL 8'h08
`define OFS_IRQ_MASK 8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_CLOCK_SOURCE_SELECT 5
`define BIT_COUNT_EDGE_POLARITY 4
`define BIT_PRESCALER_ASSIGN 3
`define BIT_RATIO_HI 2
`define BIT_RATIO_LO 0
`define BIT_OVERFLOW_IRQ_ENABLE 5
`define BIT_OVERFLOW_FLAG 2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_COUNT_VALUE 8'h00
`define RST_OPTION 8'hff
`define RST_IRQ_CONTROL 8'h00
`define RST_IRQ_MASK 8'h04
`define WRITE_INHIBIT_CYCLES 2'h2

`endif

// [include/timer0_pkg.sv]
package timer0_pkg;

  // Clock source of the counter
  typedef enum logic {src_instr, src_pin} clk_src_t;

  // Prescaler state
  typedef struct packed {
    logic [7:0] cnt;
  } presc_state_t;

  // Timer state
  typedef struct packed {
    logic [7:0] count;
    logic [1:0] inhibit;
    clk_src_t src;
    logic edge_pol;
    logic presc_assign;
    logic [2:0] ratio;
    logic ovf_en;
    logic ovf_flag;
    logic ovf_mask;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic [31:0] rdata;
    logic slverr;
  } timer_state_t;

endpackage : timer0_pkg

// [logic/prescaler_unit.sv]
`timescale 1ns/1ps
module prescaler_unit (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Control
  input logic clear,
  input logic [7:0] mask,
  // Ticks
  input logic tick_in,
  output logic tick_out
);
  import timer0_pkg::*;

  presc_state_t s_q;
  presc_state_t s_d;

  // Output fires on the tick that completes a full group of counts
  assign tick_out = tick_in && ((s_q.cnt & mask) == mask);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Internal count has no bus path at all
  always_comb
  begin
    s_d = s_q;
    if (clear)
    begin
      s_d.cnt = 8'h00;
    end
    else if (tick_in)
    begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : prescaler_unit

// [sim/ext_pulse_source.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Count pin source
// ----------------------------------------
module ext_pulse_source (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Request
  input logic start,
  input logic [3:0] toggles,
  // Pin
  output logic pin
);
  logic [3:0] left_q;
  logic [1:0] div_q;
  // Slow toggles, so each level outlives the synchroniser
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      left_q <= 4'h0;
      div_q <= 2'h0;
      pin <= 1'b0;
    end
    else if (start)
    begin
      left_q <= toggles;
      div_q <= 2'h0;
    end
    else if (left_q != 4'h0)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
      begin
        pin <= ~pin;
        left_q <= left_q - 4'h1;
      end
    end
  end
endmodule : ext_pulse_source

// [sim/timer0_counter_prescaler_props.sv]
`timescale 1ns/1ps
module timer0_counter_prescaler_props (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Register bus
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Interrupt
  input logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic acc;
  logic mapped;
  // ----------------------------------------
  // Access decode and gating steps
  // ----------------------------------------
  assign acc = psel && penable;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
  sequence s_en_off;
    acc && pwrite && paddr == 8'h08 && !pwdata[5];
  endsequence
  sequence s_mask_off;
    acc && pwrite && paddr == 8'h0c && !pwdata[2];
  endsequence
  AST_READY: assert property (pready) else $error("ready low");
  AST_ERR_UNMAP: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped");
  AST_ERR_MAP: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped");
  AST_UPPER_ZERO: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_UNMAP_ZERO: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_OPT_TOP: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata[7:6] == 2'h3)
    else $error("option top bits");
  AST_RD_HOLD: assert property (acc |=> $stable(prdata)) else $error("read data moved");
  AST_EN_OFF: assert property (s_en_off |-> ##2 !irq) else $error("irq with enable off");
  AST_MASK_OFF: assert property (s_mask_off |-> ##2 !irq) else $error("irq masked");
  AST_RST_IDLE: assert property (disable iff (1'b0) !rst_n |=> !irq && !pslverr)
    else $error("outputs after reset");
endmodule : timer0_counter_prescaler_props

bind timer0_counter_prescaler timer0_counter_prescaler_props i_props (.clock(clock),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// [sim/timer0_counter_prescaler_bench.sv]
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (x)); end end
module timer0_counter_prescaler_bench;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, sleep, pin, start, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] tg;
  logic wt, ws;
  int n_fail, compares, nws;
  typedef struct {logic [7:0] opt; logic [3:0] tg; int w; logic [7:0] lo; logic [7:0] hi;} row_t;
  row_t rows[11];
  // Watchdog tick driven by the bench to reach the shared prescaler
  timer0_counter_prescaler i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(pin), .sleep(sleep), .watchdog_tick(wt),
    .watchdog_scaled_tick(ws), .irq(irq));
  ext_pulse_source i_src (.clock(clock), .rst_n(rst_n), .start(start), .toggles(tg), .pin(pin));
  // ----------------------------------------
  // Bus tasks and verdict
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Free-running clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Hang guard, well past the longest path
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report;
  end
  // Main sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, sleep, start, wt} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    tg = 4'h0;
    for (int i = 0; i < 8; i++) rows[i] = '{8'(i), 4'h0, 5 << (i + 1), 8'h4, 8'h6};
    rows[8] = '{8'h08, 4'h0, 20, 8'h13, 8'h13};
    rows[9] = '{8'h28, 4'h3, 30, 8'h2, 8'h2};
    rows[10] = '{8'h38, 4'h3, 30, 8'h2, 8'h2};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, 8'h00, 0); `CHK(r, 32'h0)
    apb(0, 8'h04, 0); `CHK(r, 32'hff)
    apb(0, 8'h08, 0); `CHK(r, 32'h0)
    apb(0, 8'h0c, 0); `CHK(r, 32'h4)
    apb(1, 8'h10, 32'h5a); `CHK(e, 1'b1)
    apb(0, 8'h10, 0); `CHK({e, r}, {1'b1, 32'h0})
    apb(1, 8'h00, 32'ha5);
    apb(0, 8'h00, 0); `CHK(r, 32'ha5)
    // Ratio, mode and edge rows
    for (int i = 0; i < 11; i++)
    begin
      apb(1, 8'h04, {24'h0, rows[i].opt});
      apb(1, 8'h00, 0);
      tg <= rows[i].tg;
      start <= (rows[i].tg != 4'h0);
      @(posedge clock);
      start <= 1'b0;
      idle(rows[i].w - 1);
      apb(0, 8'h00, 0);
      `CHK(r[7:0] >= rows[i].lo && r[7:0] <= rows[i].hi, 1'b1)
    end
    // Two lost ticks after a counter write
    apb(1, 8'h04, 32'h08);
    apb(1, 8'h00, 32'h40);
    apb(0, 8'h00, 0); `CHK(r, 32'h40)
    apb(0, 8'h00, 0); `CHK(r, 32'h42)
    // Frozen in sleep, resumes after
    apb(1, 8'h00, 0);
    sleep <= 1'b1;
    idle(30);
    apb(0, 8'h00, 0); `CHK(r, 32'h0)
    sleep <= 1'b0;
    idle(10);
    apb(0, 8'h00, 0); `CHK(r[7:0] != 8'h0, 1'b1)
    // Overflow flag, enable and mask
    apb(1, 8'h08, 32'h20);
    apb(1, 8'h00, 32'hf0);
    idle(25); `CHK(irq, 1'b1)
    apb(0, 8'h08, 0); `CHK(r, 32'h24)
    apb(1, 8'h0c, 0);
    idle(2); `CHK(irq, 1'b0)
    apb(1, 8'h0c, 32'h4);
    idle(2); `CHK(irq, 1'b1)
    apb(1, 8'h08, 0);
    idle(2); `CHK(irq, 1'b0)
    apb(0, 8'h08, 0); `CHK(r, 32'h04)
    apb(1, 8'h08, 32'h24);
    apb(0, 8'h08, 0); `CHK(r, 32'h20)
    `CHK(irq, 1'b0)
    // Watchdog side: pass-through, then 1:2 and 1:4 over eight ticks
    for (int k = 0; k < 3; k++)
    begin
      apb(1, 8'h04, {24'h0, 8'(k == 0 ? 0 : 8 + k)});
      nws = 0;
      wt <= 1'b1;
      repeat (8)
      begin
        @(posedge clock);
        nws += ws;
      end
      wt <= 1'b0;
      `CHK(nws, 8 >> k)
    end
    // Reset in mid-run, with a pending request
    apb(1, 8'h08, 32'h20);
    apb(1, 8'h00, 32'hfe);
    idle(8); `CHK(irq, 1'b1)
    rst_n <= 1'b0;
    idle(3); `CHK(irq, 1'b0)
    rst_n <= 1'b1;
    apb(0, 8'h00, 0); `CHK(r, 32'h0)
    apb(0, 8'h04, 0); `CHK(r, 32'hff)
    apb(0, 8'h08, 0); `CHK(r, 32'h0)
    final_report;
  end
endmodule : timer0_counter_prescaler_bench
